// file: sdmi_core.sv
// sdram device side: mode register, bank rows, burst column generation
`timescale 1ns/1ps
`default_nettype none
module sdmi_core
	import sdmi_pkg::*;
#(
	parameter int NBANK = 4,
	parameter logic [1:0] WIDTH = WIDTH_X16
)(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              cke,
	input  wire sdmi_cmd_t         cmd,
	output sdmi_mode_t             mode,
	output logic                   mode_valid,
	output logic                   mode_legal,
	output logic [NBANK-1:0]       bank_open,
	output logic [ROW_BITS-1:0]    act_row,
	output logic [COL_BITS-1:0]    col_addr,
	output logic                   col_valid,
	output logic                   col_write,
	output logic                   dq_oe,
	output logic                   dq_oe_req
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_BURST = 3'b010,
		ST_DRAIN = 3'b100
	} sdmi_st_t;
	sdmi_st_t state_reg, state_next;
	logic [MODE_BITS-1:0]  mode_reg;
	logic                  mvalid_reg;
	logic [NBANK-1:0]      open_reg;
	logic [ROW_BITS-1:0]   row_reg [NBANK];
	logic [1:0]            bank_reg;
	logic [COL_BITS-1:0]   start_reg;
	logic [COL_BITS-1:0]   step_reg;
	logic                  wr_reg;
	logic [2:0]            blen_reg;
	logic                  ilv_reg;
	logic [COL_BITS-1:0]   col_reg;
	logic                  cvalid_reg;
	logic [2:0]            rdpipe_reg;
	wire logic [3:0]       op;
	wire logic [1:0]       bank;
	wire logic             is_load;
	wire logic             is_act;
	wire logic             is_rw;
	wire logic             is_term;
	wire logic             is_pre;
	wire logic [COL_BITS-1:0] cmask;
	wire logic [COL_BITS-1:0] rw_col;
	wire logic [2:0]       eff_blen;
	wire logic [3:0]       last_step;
	wire logic             burst_done;
	wire logic [COL_BITS-1:0] seq_col;
	wire logic [2:0]       rd_lat;
	// command decode on the rising edge; cke low masks every command (see R1)
	assign op      = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
	assign bank    = {cmd.bank_select_high, cmd.bank_select_low};
	assign is_load = cke && (op == CMD_LOAD) && (bank == 2'h0); // see R11
	assign is_act  = cke && (op == CMD_ACT);
	assign is_rw   = cke && ((op == CMD_READ) || (op == CMD_WRITE))
	               && open_reg[bank] && mvalid_reg; // see R3, R10
	assign is_term = cke && (op == CMD_TERM);
	assign is_pre  = cke && (op == CMD_PRE);
	// column width per organisation (see R2, R4)
	assign cmask   = (WIDTH == WIDTH_X4) ? 12'h0BFF :
	                 (WIDTH == WIDTH_X8) ? 12'h03FF : 12'h01FF;
	assign rw_col  = {cmd.addr[11], 1'b0, cmd.addr[9:0]} & cmask;
	// write-single forces length one on writes only (see R22)
	assign eff_blen = (op == CMD_WRITE && mode_reg[WSINGLE_POS]) ? BL_ONE
	                : mode_reg[BL_LSB +: 3];
	assign last_step = (blen_reg == BL_TWO)   ? 4'h1 : // see R26
	                   (blen_reg == BL_FOUR)  ? 4'h3 :
	                   (blen_reg == BL_EIGHT) ? 4'h7 : 4'h0;
	assign burst_done = (blen_reg != BL_PAGE)
	                  && (step_reg == COL_BITS'(last_step));
	assign rd_lat  = mode_reg[RD_LSB +: 3];
	// interleave is ignored at length one and not offered at full page
	assign mode_legal = mvalid_reg
		&& (mode_reg[OPMODE_HI_POS:OPMODE_LOW_POS] == 2'h0)       // see R21
		&& (rd_lat == RD_TWO || rd_lat == RD_THREE)               // see R24
		&& (mode_reg[2:0] <= BL_EIGHT
		    || (mode_reg[2:0] == BL_PAGE && !mode_reg[ORDER_POS])); // see R17
	sdmi_colseq #(.CW(COL_BITS)) u_seq (
		.start_col  (start_reg),
		.col_mask   (cmask),
		.step       (step_reg),
		.interleave (ilv_reg),
		.blen_code  (blen_reg),
		.col        (seq_col)
	);
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:  if (is_rw) state_next = ST_BURST;
			ST_BURST:
				if (is_load || is_pre)
					state_next = ST_IDLE;
				else if (is_rw)
					state_next = ST_BURST;
				else if (is_term || burst_done) // see R18
					state_next = ST_DRAIN;
			ST_DRAIN: state_next = is_rw ? ST_BURST : ST_IDLE;
			default:  state_next = ST_IDLE;
		endcase
	end
	// mode value from address bits 0-11; bit 12 dropped (see R15, R16, R25)
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mode_reg   <= MODE_RESET;
			mvalid_reg <= 1'b0; // see R10
		end
		else if (is_load && open_reg == '0) // see R14
		begin
			mode_reg   <= {1'b0, cmd.addr[11:0]};
			mvalid_reg <= 1'b1;
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			open_reg <= '0;
		else if (is_pre)
			open_reg <= cmd.addr[10] ? '0
			          : open_reg & ~(NBANK'(1) << bank); // see R7
		else if (is_act)
			open_reg <= open_reg | (NBANK'(1) << bank); // see R3
	end
	always_ff @(posedge clk)
		if (is_act)
			row_reg[bank] <= cmd.addr[ROW_BITS-1:0];
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			step_reg  <= '0;
		end
		else
		begin
			state_reg <= state_next;
			// wide enough to walk a whole page before wrapping
			step_reg  <= is_rw ? '0 : step_reg + 1'b1; // see R20
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			start_reg <= '0;
			bank_reg  <= 2'h0;
			wr_reg    <= 1'b0;
			blen_reg  <= BL_ONE;
			ilv_reg   <= 1'b0;
		end
		else if (is_rw)
		begin
			start_reg <= rw_col; // see R4
			bank_reg  <= bank;
			wr_reg    <= (op == CMD_WRITE);
			blen_reg  <= eff_blen;
			ilv_reg   <= mode_reg[ORDER_POS] && (eff_blen != BL_ONE);
		end
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			col_reg    <= '0;
			cvalid_reg <= 1'b0;
		end
		else
		begin
			col_reg    <= seq_col;
			cvalid_reg <= (state_reg == ST_BURST);
		end
	end
	// read pipe: bit k set means data due k+1 edges later (see R24)
	always_ff @(posedge clk)
	begin
		if (rst || is_load)
			rdpipe_reg <= 3'h0; // see R12
		else
			rdpipe_reg <= {1'b0, rdpipe_reg[2:1]}
			            | ((state_reg == ST_BURST && !wr_reg)
			               ? ((rd_lat == RD_THREE) ? 3'h2 : 3'h1)
			               : 3'h0);
	end
	assign mode       = sdmi_mode_t'(mode_reg[9:0]);
	assign mode_valid = mvalid_reg;
	assign bank_open  = open_reg;
	assign act_row    = row_reg[bank_reg];
	assign col_addr   = col_reg;
	assign col_valid  = cvalid_reg;
	assign col_write  = wr_reg;
	assign dq_oe_req  = rdpipe_reg[0];
	assign dq_oe      = rdpipe_reg[0] && !is_load; // see R12

	chk_load_zero_top: assert property (@(posedge clk) disable iff (rst) // see R16
		is_load && open_reg == '0 |=> !mode_reg[TOP_POS])
		else $error("mode bit 12 stored");
	chk_load_takes: assert property (@(posedge clk) disable iff (rst) // see R11
		is_load && open_reg == '0 |=> mode_reg[11:0] == $past(cmd.addr[11:0]))
		else $error("mode load value lost");
	chk_load_holds: assert property (@(posedge clk) disable iff (rst) // see R11
		!is_load |=> $stable(mode_reg))
		else $error("mode changed without load");
	chk_no_rw_unset: assert property (@(posedge clk) disable iff (rst) // see R10
		!mvalid_reg && cke && (op == CMD_READ || op == CMD_WRITE)
		|=> state_reg != ST_BURST)
		else $error("access before mode load");
	chk_oe_after_load: assert property (@(posedge clk) disable iff (rst) // see R12
		is_load |=> !dq_oe ##1 !dq_oe)
		else $error("outputs driven after load");
	chk_burst_block: assert property (@(posedge clk) disable iff (rst) // see R19
		state_reg == ST_BURST && blen_reg == BL_EIGHT && !is_rw
		|=> col_reg[COL_BITS-1:3] == start_reg[COL_BITS-1:3])
		else $error("burst left its block");
	chk_burst_term: assert property (@(posedge clk) disable iff (rst) // see R18
		state_reg == ST_BURST && is_term && !is_rw |=> state_reg == ST_DRAIN)
		else $error("terminate ignored");
	chk_write_single: assert property (@(posedge clk) disable iff (rst) // see R22
		is_rw && op == CMD_WRITE && mode_reg[WSINGLE_POS]
		|=> blen_reg == BL_ONE)
		else $error("write burst in single mode");
	chk_read_lat: assert property (@(posedge clk) disable iff (rst) // see R24
		state_reg == ST_BURST && !wr_reg && rd_lat == RD_THREE && !is_load
		##1 !is_load |=> dq_oe_req)
		else $error("read latency wrong");
endmodule
`default_nettype wire

// file: sdmi_pkg.sv
// package: command codes, mode register layout and geometry for the sdram init and mode block
// Operation
// R1: all command, bank and address inputs are taken on the rising clock edge.
// R2: four banks of 8192 rows; 2048x4, 1024x8 or 512x16 columns.
// R3: access opens with ACTIVE; bank bits pick bank, address bits 0-12 pick row.
// R4: READ/WRITE address gives start column; width decides which bits count.
// R5: controller waits 100 us after power before any real command.
// R6: controller holds clock enable low, raises it during wait, sends inhibit or NOP.
// R7: precharge-all then NOP for recovery time brings all banks idle.
// R8: at least two auto-refreshes, each followed by refresh cycle time of NOPs.
// R9: the two init refreshes may instead follow the mode load.
// R10: mode register powers up unknown; must be loaded before operational commands.
// R11: mode load needs both bank bits zero; value held until rewritten.
// R12: data outputs stay high impedance after a mode load.
// R13: after mode load only NOP or deselect for the mode set delay.
// R14: mode load only with all banks idle, then wait before next operation.
// R15: fields: length 0-2, type 3, latency 4-6, opmode 7-8, write mode 9.
// R16: address bit 12 is meaningless in mode load; controller drives it low.
// R17: lengths 1,2,4,8 both types; full page sequential only; reserved codes unused.
// R18: burst terminate stops a burst, giving arbitrary lengths from full page.
// R19: burst stays in an aligned block of its length and wraps at the boundary.
// R20: full-page burst wraps inside the row until terminated.
// R21: normal operation needs both opmode bits zero; others reserved or test.
// R22: write-single bit set makes writes one location; reads keep programmed length.
// R23: burst-type bit picks sequential or interleaved order within the block.
// R24: read latency is two or three clocks from READ to first data.
// R25: during mode load address bits 0-11 carry the new mode value.
// R26: length codes 000,001,010,011 and 111 full page; latency codes 010,011.
// R27: controller sequences init with counted waits given as clock cycles.
package sdmi_pkg;
	localparam int ROW_BITS       = 13;
	localparam int COL_BITS       = 12;
	localparam int ADDR_BITS      = 13;
	localparam int MODE_BITS      = 13;
	localparam int BL_LSB         = 0;
	localparam int ORDER_POS      = 3;
	localparam int RD_LSB         = 4;
	localparam int OPMODE_LOW_POS = 7;
	localparam int OPMODE_HI_POS  = 8;
	localparam int WSINGLE_POS    = 9;
	localparam int TOP_POS        = 12;
	localparam logic [2:0] BL_ONE  = 3'h0;
	localparam logic [2:0] BL_TWO  = 3'h1;
	localparam logic [2:0] BL_FOUR = 3'h2;
	localparam logic [2:0] BL_EIGHT = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] RD_TWO   = 3'h2;
	localparam logic [2:0] RD_THREE = 3'h3;
	localparam logic [12:0] MODE_RESET = 13'h0000;
	localparam logic [1:0] WIDTH_X4  = 2'h0;
	localparam logic [1:0] WIDTH_X8  = 2'h1;
	localparam logic [1:0] WIDTH_X16 = 2'h2;
	// {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP   = 4'h7;
	localparam logic [3:0] CMD_ACT   = 4'h3;
	localparam logic [3:0] CMD_READ  = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_TERM  = 4'h6;
	localparam logic [3:0] CMD_PRE   = 4'h2;
	localparam logic [3:0] CMD_REF   = 4'h1;
	localparam logic [3:0] CMD_LOAD  = 4'h0;
	typedef struct packed {
		logic                 cs_n;
		logic                 ras_n;
		logic                 cas_n;
		logic                 we_n;
		logic                 bank_select_high;
		logic                 bank_select_low;
		logic [ADDR_BITS-1:0] addr;
	} sdmi_cmd_t;
	typedef struct packed {
		logic                 write_single_bit;
		logic                 opmode_bit_high;
		logic                 opmode_bit_low;
		logic [2:0]           read_delay_cycles;
		logic                 burst_order_bit;
		logic [2:0]           burst_count;
	} sdmi_mode_t;
endpackage

// file: sdmi_colseq.sv
// column sequencer: one burst step inside the aligned block or the page
`timescale 1ns/1ps
`default_nettype none
module sdmi_colseq
	import sdmi_pkg::*;
#(
	parameter int CW = COL_BITS
)(
	input  wire logic [CW-1:0] start_col,
	input  wire logic [CW-1:0] col_mask,
	input  wire logic [CW-1:0] step,
	input  wire logic          interleave,
	input  wire logic [2:0]    blen_code,
	output logic      [CW-1:0] col
);
	wire logic [2:0] lo_seq;
	wire logic [2:0] lo_int;
	wire logic [2:0] lo_mask;
	wire logic [2:0] lo_new;
	wire logic [CW-1:0] page_col;
	assign lo_seq   = start_col[2:0] + step[2:0];
	assign lo_int   = start_col[2:0] ^ step[2:0];
	assign lo_mask  = (blen_code == BL_TWO)   ? 3'h1 :
	                  (blen_code == BL_FOUR)  ? 3'h3 :
	                  (blen_code == BL_EIGHT) ? 3'h7 : 3'h0;
	// low bits move, block bits stay: wrap inside the block (see R19, R23)
	assign lo_new   = ((interleave ? lo_int : lo_seq) & lo_mask)
	                | (start_col[2:0] & ~lo_mask);
	// ones in the unused column bits carry the sum across the x4 gap at
	// bit 10 and out of the top, so the page wraps inside the row
	assign page_col = ((start_col | ~col_mask) + step) & col_mask; // see R20
	assign col = (blen_code == BL_PAGE) ? page_col
	           : {start_col[CW-1:3], lo_new};
endmodule
`default_nettype wire

// file: sdmi_ctl_model.sv
// controller model: power-up sequence and command issue for the sdram block
`timescale 1ns/1ps
`default_nettype none
module sdmi_ctl_model
	import sdmi_pkg::*;
#(
	parameter int PWR_CYC = 2000,
	parameter int RP_CYC  = 1,
	parameter int RFC_CYC = 2,
	parameter int MRD_CYC = 2
)(
	input  wire logic clk,
	output var  logic cke,
	output var  sdmi_cmd_t cmd
);
	initial
	begin
		cke = 1'b0;
		cmd = {CMD_NOP, 2'h0, 13'h0000};
	end
	task automatic issue(input logic [3:0] op, input logic [1:0] ba,
		input logic [12:0] a);
		@(negedge clk);
		cmd = {op, ba, a};
		@(negedge clk);
		// released lines show the inverse, so a stale copy cannot pass
		cmd = {CMD_NOP, ~ba, ~a};
	endtask
	task automatic nops(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic refresh_pair();
		repeat (2)
		begin
			issue(CMD_REF, 2'h0, 13'h0000);
			nops(RFC_CYC);
		end
	endtask
	task automatic power_up();
		nops(PWR_CYC / 2);
		cke = 1'b1;
		nops(PWR_CYC / 2);
		issue(CMD_PRE, 2'h0, 13'h0400);
		nops(RP_CYC);
		refresh_pair();
	endtask
	task automatic load_mode(input logic [11:0] m);
		issue(CMD_LOAD, 2'h0, {1'b0, m});
		nops(MRD_CYC);
	endtask
endmodule
`default_nettype wire

// file: sdram_init_and_mode_setup_tb.sv
// testbench for the sdram init and mode block
`timescale 1ns/1ps
`default_nettype none
module sdram_init_and_mode_setup_tb
	import sdmi_pkg::*;
;
	logic                clk;
	logic                rst;
	logic                cke;
	sdmi_cmd_t           cmd;
	sdmi_mode_t          mode;
	logic                mode_valid;
	logic                mode_legal;
	logic [3:0]          bank_open;
	logic [ROW_BITS-1:0] act_row;
	logic [COL_BITS-1:0] col_addr;
	logic                col_valid;
	logic                col_write;
	logic                dq_oe;
	logic                dq_oe_req;
	int                  error_cnt = 0;
	int                  tests_run = 0;
	localparam logic [12:0] MODES [8] = '{13'h0020, 13'h0021, 13'h0032,
		13'h002a, 13'h0023, 13'h003b, 13'h0029, 13'h0038};
	localparam int STARTS [8] = '{'h15, 'h01, 'h06, 'h05, 'h1fd, 'ha3,
		'h1ff, 'h44};
	sdmi_core #(.NBANK(4), .WIDTH(WIDTH_X16)) uut (.clk(clk), .rst(rst),
		.cke(cke), .cmd(cmd), .mode(mode), .mode_valid(mode_valid),
		.mode_legal(mode_legal), .bank_open(bank_open), .act_row(act_row),
		.col_addr(col_addr), .col_valid(col_valid), .col_write(col_write),
		.dq_oe(dq_oe), .dq_oe_req(dq_oe_req));
	sdmi_ctl_model ctl (.clk(clk), .cke(cke), .cmd(cmd));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// n of 0 runs the whole programmed length
	task automatic burst(input logic [3:0] op, input logic [1:0] ba,
		input int col, input int n, input logic [12:0] m);
		int bl;
		int e;
		bl = (m[2:0] == BL_PAGE) ? 512 : (1 << m[2:0]);
		if (n == 0)
			n = bl;
		ctl.issue(op, ba, col[12:0]);
		for (int i = 0; i < n; i++)
		begin
			@(negedge clk);
			e = (col & ~(bl - 1)) | ((m[3] ? col ^ i : col + i) & (bl - 1));
			chk("col_valid", 1, col_valid);
			chk("col_addr", e, col_addr);
			chk("col_write", op == CMD_WRITE, col_write);
			if (op == CMD_READ && i == m[6:4] - 2)
				chk("dq_oe_req", 1, dq_oe_req);
		end
		if (bl == 512)
			ctl.issue(CMD_TERM, ba, 13'h0000);
		if (bl == 512)
			repeat (2) @(negedge clk);
		else
			@(negedge clk);
		chk("burst_end", 0, col_valid);
	endtask
	initial
	begin
		repeat (10000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end
	initial
	begin
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		chk("mode_valid", 0, mode_valid);
		chk("bank_open", 0, bank_open);
		ctl.power_up();
		ctl.issue(CMD_ACT, 2'h0, 13'h0005);
		ctl.issue(CMD_READ, 2'h0, 13'h0000);
		repeat (2) @(negedge clk);
		chk("unloaded_read", 0, col_valid);
		for (int r = 0; r < 8; r++)
		begin
			ctl.issue(CMD_PRE, 2'h0, 13'h0400);
			ctl.load_mode(MODES[r][11:0]);
			chk("mode", MODES[r][9:0], mode);
			chk("mode_legal", 1, mode_legal);
			ctl.issue(CMD_ACT, r[1:0], 13'h1000 | r[12:0]);
			chk("bank_open", 1 << r[1:0], bank_open);
			burst(CMD_READ, r[1:0], STARTS[r], 0, MODES[r]);
			chk("act_row", 13'h1000 | r[12:0], act_row);
		end
		ctl.issue(CMD_LOAD, 2'h0, 13'h0033);
		chk("open_load", MODES[7][9:0], mode);
		ctl.issue(CMD_PRE, 2'h0, 13'h0400);
		ctl.issue(CMD_LOAD, 2'h1, 13'h0033);
		chk("bank_load", MODES[7][9:0], mode);
		ctl.load_mode(12'h1a3);
		chk("opmode_legal", 0, mode_legal);
		ctl.load_mode(12'h042);
		chk("latency_legal", 0, mode_legal);
		ctl.load_mode(12'h027);
		ctl.issue(CMD_ACT, 2'h0, 13'h0007);
		burst(CMD_READ, 2'h0, 'h1fe, 4, 13'h0027);
		ctl.issue(CMD_PRE, 2'h0, 13'h0400);
		ctl.load_mode(12'h222);
		chk("dq_oe", 0, dq_oe);
		ctl.issue(CMD_ACT, 2'h0, 13'h0009);
		burst(CMD_WRITE, 2'h0, 'h012, 1, 13'h0222);
		burst(CMD_READ, 2'h0, 'h012, 0, 13'h0222);
		// a load hitting a live read must drop the read data enable
		ctl.issue(CMD_READ, 2'h0, 13'h0012);
		ctl.issue(CMD_LOAD, 2'h0, 13'h0033);
		chk("dq_oe_load", 0, dq_oe_req);
		chk("busy_load", 10'h222, mode);
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		chk("rst_mode_valid", 0, mode_valid);
		chk("rst_bank_open", 0, bank_open);
		chk("rst_col_valid", 0, col_valid);
		ctl.load_mode(12'h023);
		ctl.refresh_pair();
		chk("late_refresh", 10'h023, mode);
		chk("late_legal", 1, mode_legal);
		tally_and_finish();
	end
endmodule
`default_nettype wire
